// >>> inc/sctf_pkg.sv
// constants and types for the smart card transmit-end and format block
package sctf_pkg;
  localparam int          CLK_MHZ        = 125;
  localparam logic [7:0]  ADDR_STATUS    = 8'h00;
  localparam logic [7:0]  ADDR_SCMODE    = 8'h04;
  localparam logic [7:0]  ADDR_CTRL      = 8'h08;
  localparam logic [7:0]  ADDR_ETU       = 8'h0C;
  localparam logic [7:0]  ADDR_INT_STAT  = 8'h10;
  localparam logic [7:0]  ADDR_INT_MASK  = 8'h14;
  // status register fields
  localparam int          ST_MP_TX       = 0;
  localparam int          ST_MP_RX       = 1;
  localparam int          ST_TX_END      = 2;
  localparam int          ST_ERS         = 4;
  // smart card mode register fields
  localparam int          SCM_ENABLE     = 0;
  localparam int          SCM_INVERT     = 2;
  localparam int          SCM_MSB_FIRST  = 3;
  localparam logic [7:0]  SCM_FIXED_ONES = 8'hF2;
  localparam logic [7:0]  SCM_RESET      = 8'hF2;
  // control register fields
  localparam int          CTL_GUARD      = 0;
  localparam int          CTL_BLOCK      = 1;
  localparam int          CTL_EIGHT_BIT  = 2;
  localparam logic [2:0]  CTL_RESET      = 3'h4;
  // etu length in clock cycles
  localparam logic [15:0] ETU_RESET      = 16'h0174;
  // interrupt status fields
  localparam int          IRQ_TX_END     = 0;
  localparam int          IRQ_ERR        = 1;
  localparam int          IRQ_BITS       = 2;
  // set delays in half etu units
  localparam logic [2:0]  HALVES_NORMAL  = 3'h5;
  localparam logic [2:0]  HALVES_BLOCK   = 3'h3;
  localparam logic [2:0]  HALVES_GUARD   = 3'h2;

  typedef struct packed {
    logic eight_bit;
    logic msb_first;
    logic invert;
  } sctf_fmt_cfg_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
  } sctf_bus_req_t;
endpackage

// >>> rtl/sctf_data_fmt.sv
// bit order and inversion of data bytes (parity untouched)
`timescale 1ns/1ns
module sctf_data_fmt (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  input  wire sctf_pkg::sctf_fmt_cfg_t i_cfg,
  input  wire logic [7:0]              i_data,
  output logic [7:0]                   o_data
);
  import sctf_pkg::*;

  logic [7:0] rev;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_rev
      assign rev[g] = i_data[7 - g];
    end
  endgenerate

  wire        use_rev = i_cfg.msb_first && i_cfg.eight_bit;
  wire [7:0]  ordered = use_rev ? rev : i_data;
  wire [7:0]  shaped  = i_cfg.invert ? ~ordered : ordered;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data <= 8'h00;
    end else begin
      o_data <= shaped;
    end
  end
endmodule

// >>> rtl/sctf_etu_timer.sv
// half-etu delay timer started at transmission start
`timescale 1ns/1ns
module sctf_etu_timer (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_start,
  input  wire logic        i_abort,
  input  wire logic [15:0] i_half_etu,
  input  wire logic [2:0]  i_halves,
  output logic             o_done,
  output logic             o_busy
);
  import sctf_pkg::*;

  logic [15:0] cyc;
  logic [2:0]  halves;
  wire         half_tick = (cyc >= i_half_etu - 16'h0001);
  wire         last      = half_tick && (halves == 3'h1);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc    <= 16'h0000;
      halves <= 3'h0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= o_busy && !i_abort && !i_start && last;
      if (i_start) begin
        cyc    <= 16'h0000;
        halves <= i_halves;
        o_busy <= 1'b1;
      end else if (i_abort || (o_busy && last)) begin
        o_busy <= 1'b0;
      end else if (o_busy) begin
        cyc    <= half_tick ? 16'h0000 : cyc + 16'h0001;
        halves <= half_tick ? halves - 3'h1 : halves;
      end
    end
  end
endmodule

// >>> rtl/sctf_top.sv
// smart card transmit-end status, mode register and data format
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ns
module sctf_top (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_nrst,
  input  wire logic [7:0]             i_avs_address,
  input  wire logic                   i_avs_read,
  input  wire logic                   i_avs_write,
  input  wire logic [31:0]            i_avs_writedata,
  output logic [31:0]                 o_avs_readdata,
  output logic                        o_avs_waitrequest,
  input  wire logic                   i_transmit_enable,
  input  wire logic                   i_error_signal_status,
  input  wire logic                   i_tx_holding_empty,
  input  wire logic                   i_tx_start,
  input  wire logic                   i_tx_empty_irq_xfer,
  input  wire logic [7:0]             i_tx_byte,
  input  wire logic [7:0]             i_rx_byte,
  output logic [7:0]                  o_tx_byte,
  output logic [7:0]                  o_rx_byte,
  output logic                        o_transmit_end_flag,
  output logic                        o_smart_card_enable,
  output logic                        o_multiproc_tx_bit,
  output logic                        o_irq
);
  import sctf_pkg::*;

  // reset release through two flip-flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // request carrier
  sctf_bus_req_t req;
  assign req.read      = i_avs_read;
  assign req.write     = i_avs_write;
  assign req.address   = i_avs_address;
  assign req.writedata = i_avs_writedata;

  // registers
  logic                tx_end;
  logic                transmit_end_flag_armed;
  logic                mp_tx;
  logic [7:0]          scmode;
  logic [2:0]          ctrl;
  logic [15:0]         etu_len;
  logic [IRQ_BITS-1:0] int_stat;
  logic [IRQ_BITS-1:0] int_mask;
  logic                ers_q;
  logic                waitreq;

  // bus decode: answer one cycle after the request is seen
  wire        req_any   = req.read || req.write;
  wire        accept    = req_any && !waitreq;
  wire        wr_ok     = accept && req.write;
  wire        rd_ok     = accept && req.read;
  wire        sel_stat  = (req.address == ADDR_STATUS);
  wire        sel_scm   = (req.address == ADDR_SCMODE);
  wire        sel_ctrl  = (req.address == ADDR_CTRL);
  wire        sel_etu   = (req.address == ADDR_ETU);
  wire        sel_istat = (req.address == ADDR_INT_STAT);
  wire        sel_imask = (req.address == ADDR_INT_MASK);
  wire        wr_stat   = wr_ok && sel_stat;
  wire        rd_stat   = rd_ok && sel_stat;

  // status read image
  // received multiprocessor bit reads 0
  wire [31:0] stat_img  = {27'h0000000, ers_q, 1'b0, tx_end, 1'b0, mp_tx};
  // reserved mode bits forced to 1
  wire [7:0]  scm_img   = scmode | SCM_FIXED_ONES;
  wire [31:0] rd_mux    =
    sel_stat  ? stat_img :
    sel_scm   ? {24'h000000, scm_img} :
    sel_ctrl  ? {29'h00000000, ctrl} :
    sel_etu   ? {16'h0000, etu_len} :
    sel_istat ? {30'h00000000, int_stat} :
    sel_imask ? {30'h00000000, int_mask} : 32'h00000000;

  // bus answer sequence: a request waits one cycle, then is answered
  typedef enum logic [0:0] {
    BUS_WAIT   = 1'b0,
    BUS_ANSWER = 1'b1
  } sctf_bus_state_t;

  sctf_bus_state_t bus_state;
  sctf_bus_state_t next_bus_state;

  always_comb begin
    next_bus_state = BUS_WAIT;
    case (bus_state)
      BUS_WAIT: begin
        next_bus_state = req_any ? BUS_ANSWER : BUS_WAIT;
      end
      BUS_ANSWER: begin
        next_bus_state = BUS_WAIT;
      end
      default: begin
        next_bus_state = BUS_WAIT;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= BUS_WAIT;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // waitrequest and read data come straight from flip-flops
  wire        wait_next = (next_bus_state == BUS_WAIT);
  wire        rd_load   = req.read && (bus_state == BUS_WAIT);

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitreq <= 1'b1;
    end else begin
      waitreq <= wait_next;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_avs_readdata <= 32'h00000000;
    end else if (rd_load) begin
      o_avs_readdata <= rd_mux;
    end
  end
  assign o_avs_waitrequest = waitreq;

  // delay selection
  wire        guard   = ctrl[CTL_GUARD];
  wire        block   = ctrl[CTL_BLOCK];
  // 2.5 or 1.5 etu with guard mode off
  wire [2:0]  halves_off = block ? HALVES_BLOCK : HALVES_NORMAL;
  // 1.0 etu with guard mode on
  wire [2:0]  halves  = guard ? HALVES_GUARD : halves_off;
  wire [15:0] half_etu = {1'b0, etu_len[15:1]};

  // error sampled during the wait aborts the set
  wire        err_rise = i_error_signal_status && !ers_q;
  wire        t_done;

  sctf_etu_timer u_timer (
    .i_clk      (i_sys_clk),
    .i_rst_n    (rst_n),
    .i_start    (i_tx_start),
    .i_abort    (i_error_signal_status),
    .i_half_etu (half_etu),
    .i_halves   (halves),
    .o_done     (t_done),
    .o_busy     ()
  );

  // transmit end set and clear terms
  // forced high while enable and error status are low
  wire        force_set = !i_transmit_enable && !i_error_signal_status;
  // set after delay with no error and empty holding register
  wire        timed_set = t_done && !i_error_signal_status && i_tx_holding_empty;
  // zero write clears only after a read of 1
  wire        sw_clear  = wr_stat && transmit_end_flag_armed && !req.writedata[ST_TX_END];
  // transfer controller service clears the flag
  wire        hw_clear  = i_tx_empty_irq_xfer;
  // otherwise the flag holds; set wins over clear
  wire        next_tx_end = force_set || timed_set ? 1'b1 :
                            (sw_clear || hw_clear) ? 1'b0 : tx_end;
  wire        transmit_end_flag_event  = next_tx_end && !tx_end;

  // arm on a read of 1, disarm on any status write or clear
  wire        next_armed = (rd_stat && tx_end) ? 1'b1 :
                           (wr_stat || !tx_end) ? 1'b0 : transmit_end_flag_armed;

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_end     <= 1'b1;
      transmit_end_flag_armed <= 1'b0;
      ers_q      <= 1'b0;
    end else begin
      tx_end     <= next_tx_end;
      transmit_end_flag_armed <= next_armed;
      ers_q      <= i_error_signal_status;
    end
  end

  // configuration registers
  // transfer bit stored as written; software keeps it 0
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mp_tx <= 1'b0;
    end else if (wr_stat) begin
      mp_tx <= req.writedata[ST_MP_TX];
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scmode <= SCM_RESET;
    end else if (wr_ok && sel_scm) begin
      scmode <= req.writedata[7:0] | SCM_FIXED_ONES;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTL_RESET;
    end else if (wr_ok && sel_ctrl) begin
      ctrl <= req.writedata[2:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      etu_len <= ETU_RESET;
    end else if (wr_ok && sel_etu) begin
      etu_len <= req.writedata[15:0];
    end
  end

  // interrupt status, write one to clear, set wins
  wire [IRQ_BITS-1:0] irq_set = {err_rise, transmit_end_flag_event};
  wire [IRQ_BITS-1:0] irq_clr = (wr_ok && sel_istat) ? req.writedata[IRQ_BITS-1:0] :
                                {IRQ_BITS{1'b0}};
  wire [IRQ_BITS-1:0] next_int_stat = irq_set | (int_stat & ~irq_clr);

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat <= {IRQ_BITS{1'b0}};
    end else begin
      int_stat <= next_int_stat;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_mask <= {IRQ_BITS{1'b0}};
    end else if (wr_ok && sel_imask) begin
      int_mask <= req.writedata[IRQ_BITS-1:0];
    end
  end

  // level interrupt while an unmasked status bit is set
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(int_stat & int_mask);
    end
  end

  // data format paths
  sctf_fmt_cfg_t fmt_cfg;
  assign fmt_cfg.eight_bit = ctrl[CTL_EIGHT_BIT];
  assign fmt_cfg.msb_first = scmode[SCM_MSB_FIRST];
  assign fmt_cfg.invert    = scmode[SCM_INVERT];

  sctf_data_fmt u_tx_fmt (
    .i_clk   (i_sys_clk),
    .i_rst_n (rst_n),
    .i_cfg   (fmt_cfg),
    .i_data  (i_tx_byte),
    .o_data  (o_tx_byte)
  );

  sctf_data_fmt u_rx_fmt (
    .i_clk   (i_sys_clk),
    .i_rst_n (rst_n),
    .i_cfg   (fmt_cfg),
    .i_data  (i_rx_byte),
    .o_data  (o_rx_byte)
  );

  // registered status outputs
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_transmit_end_flag <= 1'b1;
    end else begin
      o_transmit_end_flag <= next_tx_end;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_smart_card_enable <= 1'b0;
    end else begin
      o_smart_card_enable <= scmode[SCM_ENABLE];
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_multiproc_tx_bit <= 1'b0;
    end else begin
      o_multiproc_tx_bit <= mp_tx;
    end
  end
endmodule

// >>> sim/sctf_asserts.sv
// port assertions for the smart card transmit-end block
`timescale 1ns/1ns
module sctf_asserts (
  input wire logic        i_sys_clk,
  input wire logic        i_nrst,
  input wire logic [7:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_transmit_enable,
  input wire logic        i_error_signal_status,
  input wire logic        i_tx_holding_empty,
  input wire logic        i_tx_start,
  input wire logic        i_tx_empty_irq_xfer,
  input wire logic [7:0]  i_tx_byte,
  input wire logic [7:0]  i_rx_byte,
  input wire logic [7:0]  o_tx_byte,
  input wire logic [7:0]  o_rx_byte,
  input wire logic        o_transmit_end_flag
);
  import sctf_pkg::*;
  // checks start once the design's own reset copy has let go
  logic [3:0] live_sr;
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      live_sr <= 4'h0;
    end else begin
      live_sr <= {live_sr[2:0], 1'h1};
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!live_sr[3]);
  logic rd_st;
  logic rd_md;
  always_ff @(posedge i_sys_clk) begin
    rd_st <= i_avs_read && o_avs_waitrequest && i_avs_address == ADDR_STATUS;
    rd_md <= i_avs_read && o_avs_waitrequest && i_avs_address == ADDR_SCMODE;
  end
  wait_one_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("waitrequest did not drop");
  ans_one_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  flag_forced_a: assert property (
    (!i_transmit_enable && !i_error_signal_status)[*2] |-> o_transmit_end_flag)
    else $error("flag not forced");
  set_cause_a: assert property (
    $rose(o_transmit_end_flag) && $past(i_transmit_enable)
    |-> $past(i_tx_holding_empty) && !$past(i_error_signal_status))
    else $error("flag set without cause");
  no_early_a: assert property (
    i_tx_start && i_transmit_enable && !o_transmit_end_flag
    |=> !o_transmit_end_flag [*8]) else $error("flag set too early");
  fall_cause_a: assert property ($fell(o_transmit_end_flag) |->
    $past(i_tx_empty_irq_xfer) || $past(i_avs_write && !o_avs_waitrequest
    && i_avs_address == ADDR_STATUS)) else $error("flag fell without cause");
  xfer_clear_a: assert property (
    i_tx_empty_irq_xfer && i_transmit_enable && !i_tx_start
    |=> !o_transmit_end_flag) else $error("flag not cleared by transfer");
  mprx_zero_a: assert property (
    rd_st && !o_avs_waitrequest |-> !o_avs_readdata[ST_MP_RX])
    else $error("rx multiprocessor bit not 0");
  fixed_ones_a: assert property (rd_md && !o_avs_waitrequest |->
    (o_avs_readdata[7:0] & SCM_FIXED_ONES) == SCM_FIXED_ONES)
    else $error("reserved mode bits not 1");
  tx_format_a: assert property (
    $countones(o_tx_byte) == $countones($past(i_tx_byte))
    || $countones(o_tx_byte) == 8 - $countones($past(i_tx_byte)))
    else $error("tx byte bits lost");
  rx_format_a: assert property (
    $countones(o_rx_byte) == $countones($past(i_rx_byte))
    || $countones(o_rx_byte) == 8 - $countones($past(i_rx_byte)))
    else $error("rx byte bits lost");
  cover property ($rose(o_transmit_end_flag));
  cover property (i_tx_empty_irq_xfer && o_transmit_end_flag);
  cover property (rd_md && !o_avs_waitrequest);
endmodule
bind sctf_top sctf_asserts chk (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_transmit_enable(i_transmit_enable), .i_error_signal_status(i_error_signal_status),
  .i_tx_holding_empty(i_tx_holding_empty), .i_tx_start(i_tx_start),
  .i_tx_empty_irq_xfer(i_tx_empty_irq_xfer), .i_tx_byte(i_tx_byte), .i_rx_byte(i_rx_byte),
  .o_tx_byte(o_tx_byte), .o_rx_byte(o_rx_byte), .o_transmit_end_flag(o_transmit_end_flag));

// >>> sim/sctf_card_model.sv
// behavioural smart card that signals a transmit error on command
`timescale 1ns/1ns
module sctf_card_model (
  input  wire logic i_clk,
  input  wire logic i_tx_start,
  input  wire logic i_reject,
  input  wire logic i_release,
  output logic      o_err_seen
);
  logic [3:0] cnt = 4'h0;
  initial o_err_seen = 1'h0;
  // error signal well before the set delay
  always @(posedge i_clk) begin
    if (i_tx_start && i_reject)
      cnt <= 4'h6;
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
    if (cnt == 4'h1)
      o_err_seen <= 1'h1;
    else if (i_release)
      o_err_seen <= 1'h0;
  end
endmodule

// >>> sim/tb.sv
// self-checking bench for the smart card transmit-end block
`timescale 1ns/1ns
module tb;
  import sctf_pkg::*;
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] scm;
    logic [7:0] din;
    logic [7:0] dout;
  } sctf_row_t;
  sctf_row_t rows [5] = '{'{8'h04, 8'hF3, 8'h1C, 8'h1C}, '{8'h04, 8'hFB, 8'h1C, 8'h38},
    '{8'h04, 8'hF7, 8'h1C, 8'hE3}, '{8'h04, 8'hFF, 8'h1C, 8'hC7}, '{8'h00, 8'hFB, 8'h1C, 8'h1C}};
  logic        clk = 1'h0, nrst = 1'h0, rd = 1'h0, wr = 1'h0, te = 1'h0, hold = 1'h1;
  logic        start = 1'h0, xfer = 1'h0, rej = 1'h0, rel = 1'h0;
  logic [7:0]  addr = 8'h00, txb = 8'h00, rxb = 8'h00, otx, orx;
  logic [31:0] wdata = 32'h0, rdata, rdat;
  logic        waitreq, error_signal_status, flag, irq, mpt, scen;
  int          miscompares = 0, cmp_count = 0, cycles = 0, n, d;
  sctf_top uut (.i_sys_clk(clk), .i_nrst(nrst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_transmit_enable(te), .i_error_signal_status(error_signal_status),
    .i_tx_holding_empty(hold), .i_tx_start(start), .i_tx_empty_irq_xfer(xfer),
    .i_tx_byte(txb), .i_rx_byte(rxb), .o_tx_byte(otx), .o_rx_byte(orx),
    .o_transmit_end_flag(flag), .o_smart_card_enable(scen), .o_multiproc_tx_bit(mpt),
    .o_irq(irq));
  sctf_card_model card (.i_clk(clk), .i_tx_start(start), .i_reject(rej), .i_release(rel),
    .o_err_seen(error_signal_status));
  initial forever #4 clk = ~clk;
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test;
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dt);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= dt;
    @(posedge clk);
    while (waitreq !== 1'h0) @(posedge clk);
    rdat = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic clr;
    bus(1'h0, ADDR_STATUS, 32'h0);
    bus(1'h1, ADDR_STATUS, 32'h0);
  endtask
  task automatic kick_wait(input int k);
    start <= 1'h1;
    @(posedge clk);
    start <= 1'h0;
    repeat (k) @(posedge clk);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    bus(1'h0, ADDR_STATUS, 32'h0);
    chk("status", 32'h04, rdat);
    bus(1'h0, ADDR_SCMODE, 32'h0);
    chk("mode", 32'hF2, rdat);
    chk("card enable", 32'h0, {31'h0, scen});
    bus(1'h0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rdat);
    $display("test reset done");
    foreach (rows[i]) begin
      bus(1'h1, ADDR_CTRL, {24'h0, rows[i].ctl});
      bus(1'h1, ADDR_SCMODE, {24'h0, rows[i].scm & 8'h0D});
      bus(1'h0, ADDR_SCMODE, 32'h0);
      chk("mode", {24'h0, rows[i].scm}, rdat);
      txb <= rows[i].din;
      rxb <= rows[i].din;
      repeat (3) @(posedge clk);
      chk("tx byte", {24'h0, rows[i].dout}, {24'h0, otx});
      chk("rx byte", {24'h0, rows[i].dout}, {24'h0, orx});
      chk("card enable", {31'h0, rows[i].scm[0]}, {31'h0, scen});
    end
    $display("test format done");
    bus(1'h1, ADDR_ETU, 32'h14);
    bus(1'h1, ADDR_INT_MASK, 32'h1);
    te <= 1'h1;
    bus(1'h1, ADDR_STATUS, 32'h4);
    chk("mp tx", 32'h0, {31'h0, mpt});
    bus(1'h1, ADDR_STATUS, 32'h0);
    chk("unarmed clear", 32'h1, {31'h0, flag});
    clr;
    chk("armed clear", 32'h0, {31'h0, flag});
    for (int m = 0; m < 4; m++) begin
      bus(1'h1, ADDR_CTRL, 32'h4 | m);
      clr;
      kick_wait(0);
      n = 0;
      while (flag !== 1'h1 && n < 99) begin
        @(posedge clk);
        n++;
      end
      d = (m[0] ? 2 : m[1] ? 3 : 5) * 10;
      chk("set delay", d + 2, n);
    end
    repeat (2) @(posedge clk);
    chk("irq set", 32'h1, {31'h0, irq});
    bus(1'h1, ADDR_INT_STAT, 32'h3);
    @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test timing done");
    bus(1'h1, ADDR_CTRL, 32'h4);
    clr;
    rej <= 1'h1;
    kick_wait(70);
    chk("flag after error", 32'h0, {31'h0, flag});
    chk("masked irq", 32'h0, {31'h0, irq});
    bus(1'h0, ADDR_STATUS, 32'h0);
    chk("error status", 32'h1, {31'h0, rdat[ST_ERS]});
    rej <= 1'h0;
    rel <= 1'h1;
    hold <= 1'h0;
    kick_wait(70);
    chk("flag not empty", 32'h0, {31'h0, flag});
    hold <= 1'h1;
    kick_wait(70);
    chk("flag set", 32'h1, {31'h0, flag});
    xfer <= 1'h1;
    @(posedge clk);
    xfer <= 1'h0;
    @(posedge clk);
    chk("transfer clear", 32'h0, {31'h0, flag});
    te <= 1'h0;
    repeat (3) @(posedge clk);
    chk("forced flag", 32'h1, {31'h0, flag});
    $display("test events done");
    te <= 1'h1;
    clr;
    chk("flag cleared", 32'h0, {31'h0, flag});
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    chk("flag in reset", 32'h1, {31'h0, flag});
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    bus(1'h0, ADDR_STATUS, 32'h0);
    chk("status after reset", 32'h04, rdat);
    $display("test mid reset done");
    end_of_test;
  end
endmodule
